// File: src/ursf_top.sv
// receive side of one serial channel: error detection, queue, status, APB
`timescale 1ns/1ps
`default_nettype none
module ursf_top #(
  parameter int BAUD16_DIV = 27
) (
  // clock, reset, freeze
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rxd,
  // bid to the arbiter
  output logic             bid_valid,
  output logic [3:0]       bid_level
);
  generate
    if (BAUD16_DIV < 1)
    begin : g_chk
      $error("ursf_top: BAUD16_DIV must be at least 1");
    end
  endgenerate

  ursf_q_if qi ();
  ursf_queue u_queue (.pclk(pclk), .presetn(presetn), .ce(ce), .q(qi));

  ursf_pkg::ursf_state_t state_ff;
  logic [15:0] div_ff;
  logic        tick;
  logic [3:0]  cnt_ff;
  logic [3:0]  nbit_ff;
  logic [7:0]  shift_ff;
  logic        par_ff;
  logic        hi_seen_ff;
  logic [10:0] hold_ff;
  logic        hold_v_ff;
  logic        ovr_ff;
  logic        cob_ff;
  logic [2:0]  latch_ff;
  logic        on_push_ff;
  logic [4:0]  mr1_ff;
  logic [1:0]  mr2_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        center;
  logic        rx_act;
  logic        done;
  logic        brk_now;
  logic        brk_end;
  logic        start_ok;
  logic        fe_now;
  logic        pe_now;
  logic        wr_acc;
  logic        rd_acc;
  logic        cmd_clr_err;
  logic        cmd_rst_rx;
  logic        push_fire;
  logic        pop_fire;
  logic [2:0]  err_set;
  logic [2:0]  err_rep;
  logic [4:0]  thr;

  // address decode shared by read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ursf_pkg::A_CMD) || (a == ursf_pkg::A_MR1) || (a == ursf_pkg::A_MR2)
           || (a == ursf_pkg::A_SR) || (a == ursf_pkg::A_RXD) || (a == ursf_pkg::A_ISR)
           || (a == ursf_pkg::A_BID);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB strobes; an access completes in its first access cycle with ce high
  assign pready      = ce;
  assign prdata      = prdata_ff;
  assign pslverr     = pslverr_ff;
  assign wr_acc      = psel & penable & pwrite & ce;
  assign rd_acc      = psel & penable & ~pwrite & ce;
  assign cmd_clr_err = wr_acc && paddr == ursf_pkg::A_CMD && pwdata[ursf_pkg::C_RST_ERR];
  assign cmd_rst_rx  = wr_acc && paddr == ursf_pkg::A_CMD && pwdata[ursf_pkg::C_RST_RX];
  assign pop_fire    = rd_acc && paddr == ursf_pkg::A_RXD && qi.head_valid;
  assign push_fire   = hold_v_ff & qi.push_ready;

  // mode registers and latch-collection selection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mr1_ff     <= ursf_pkg::MR1_RST;
      mr2_ff     <= ursf_pkg::MR2_RST;
      on_push_ff <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == ursf_pkg::A_MR1)
        mr1_ff <= pwdata[4:0];
      if (paddr == ursf_pkg::A_MR2)
        mr2_ff <= pwdata[ursf_pkg::M2_THR_LO +: 2];
      if (paddr == ursf_pkg::A_CMD && pwdata[ursf_pkg::C_ON_PUSH])
        on_push_ff <= 1'b1;
      else if (paddr == ursf_pkg::A_CMD && pwdata[ursf_pkg::C_ON_READ])
        on_push_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error reporting: head flags or sticky block latches
  assign err_rep = mr1_ff[ursf_pkg::M1_BLOCK] ? latch_ff
                 : (qi.head_valid ? qi.head[ursf_pkg::E_BRK:ursf_pkg::E_PE]
                 : 3'h0);
  assign err_set = !mr1_ff[ursf_pkg::M1_BLOCK] ? 3'h0
                 : on_push_ff ? (push_fire ? hold_ff[10:8] : 3'h0)
                 : (pop_fire ? qi.head[10:8] : 3'h0);

  // block latches; a flag arriving with the clear still sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_ff <= 3'h0;
    else if (ce)
      latch_ff <= ((cmd_clr_err | cmd_rst_rx) ? 3'h0 : latch_ff) | err_set;
  end

  // read data and error answer captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      pslverr_ff <= !addr_ok(paddr) || (!pwrite && paddr == ursf_pkg::A_CMD);
      prdata_ff  <= 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          ursf_pkg::A_MR1: prdata_ff[4:0] <= mr1_ff;
          ursf_pkg::A_MR2: prdata_ff[ursf_pkg::M2_THR_LO +: 2] <= mr2_ff;
          ursf_pkg::A_SR:
          begin
            prdata_ff[ursf_pkg::SR_READY]      <= qi.head_valid;
            prdata_ff[ursf_pkg::SR_FULL]       <= ~qi.push_ready;
            prdata_ff[ursf_pkg::SR_OVR]        <= ovr_ff;
            prdata_ff[ursf_pkg::SR_ERR_LO +: 3] <= err_rep;
          end
          ursf_pkg::A_RXD: prdata_ff[7:0] <= qi.head_valid ? qi.head[7:0] : 8'h00;
          ursf_pkg::A_ISR:
          begin
            prdata_ff[ursf_pkg::IS_BID] <= bid_valid;
            prdata_ff[ursf_pkg::IS_COB] <= cob_ff;
          end
          ursf_pkg::A_BID: prdata_ff[4:0] <= {bid_valid, bid_level};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16x sample tick from the system clock
  assign tick = (div_ff == 16'h0000);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_ff <= 16'h0000;
    else if (ce)
      div_ff <= tick ? 16'(BAUD16_DIV - 1) : div_ff - 16'h0001;
  end

  // receiver condition terms
  assign rx_act   = mr1_ff[ursf_pkg::M1_RX_EN] | mr1_ff[ursf_pkg::M1_SPECIAL];
  assign center   = tick && cnt_ff == ursf_pkg::T_BIT_LAST;
  assign start_ok = tick && state_ff == ursf_pkg::S_START && !rxd
                 && cnt_ff == ursf_pkg::T_START_OK;
  assign done     = center && state_ff == ursf_pkg::S_STOP;
  assign brk_now  = done && shift_ff == 8'h00 && !rxd
                 && !(mr1_ff[ursf_pkg::M1_PAR_EN] && par_ff);
  assign fe_now   = !rxd && shift_ff != 8'h00;
  assign pe_now   = mr1_ff[ursf_pkg::M1_PAR_EN]
                 && ((^shift_ff) ^ mr1_ff[ursf_pkg::M1_PAR_ODD]) != par_ff;
  assign brk_end  = center && state_ff == ursf_pkg::S_BRK && rxd && hi_seen_ff;

  // receive state machine, bit counters and shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff   <= ursf_pkg::S_IDLE;
      cnt_ff     <= 4'h0;
      nbit_ff    <= 4'h0;
      shift_ff   <= 8'h00;
      par_ff     <= 1'b0;
      hi_seen_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_rst_rx || !rx_act)
        state_ff <= ursf_pkg::S_IDLE;
      else if (tick)
      begin
        cnt_ff <= cnt_ff + 4'h1;
        case (state_ff)
          ursf_pkg::S_IDLE:
            if (!rxd)
            begin
              state_ff <= ursf_pkg::S_START;
              cnt_ff   <= 4'h0;
            end
          ursf_pkg::S_START:
            if (rxd)
              state_ff <= ursf_pkg::S_IDLE;
            else if (start_ok)
            begin
              state_ff <= ursf_pkg::S_DATA;
              cnt_ff   <= 4'h0;
              nbit_ff  <= 4'h0;
            end
          ursf_pkg::S_DATA:
            if (center)
            begin
              shift_ff <= {rxd, shift_ff[7:1]};
              nbit_ff  <= nbit_ff + 4'h1;
              if (nbit_ff == ursf_pkg::N_DATA - 4'h1)
                state_ff <= mr1_ff[ursf_pkg::M1_PAR_EN] ? ursf_pkg::S_PAR : ursf_pkg::S_STOP;
            end
          ursf_pkg::S_PAR:
            if (center)
            begin
              par_ff   <= rxd;
              state_ff <= ursf_pkg::S_STOP;
            end
          ursf_pkg::S_STOP:
            if (center)
            begin
              state_ff   <= brk_now ? ursf_pkg::S_BRK : ursf_pkg::S_IDLE;
              hi_seen_ff <= 1'b0;
            end
          ursf_pkg::S_BRK:
            if (center)
            begin
              hi_seen_ff <= rxd;
              if (brk_end)
                state_ff <= ursf_pkg::S_IDLE;
            end
          default: state_ff <= ursf_pkg::S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift-register holder in front of the queue
  assign qi.push_valid = hold_v_ff;
  assign qi.push_data  = hold_ff;
  assign qi.pop        = pop_fire;
  assign qi.flush      = cmd_rst_rx;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_ff   <= 11'h000;
      hold_v_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (cmd_rst_rx)
        hold_v_ff <= 1'b0;
      else if (done)
      begin
        // a full queue leaves the character waiting here
        // a newer one simply overwrites it
        hold_ff   <= brk_now ? {3'b100, 8'h00} : {1'b0, fe_now, pe_now, shift_ff};
        hold_v_ff <= 1'b1;
      end
      else if (push_fire)
        hold_v_ff <= 1'b0;
    end
  end

  // overrun and change-of-break flags; set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_ff <= 1'b0;
      cob_ff <= 1'b0;
    end
    else if (ce)
    begin
      ovr_ff <= ((cmd_clr_err | cmd_rst_rx) ? 1'b0 : ovr_ff)
              | (start_ok & hold_v_ff & ~qi.push_ready);
      cob_ff <= ((wr_acc && paddr == ursf_pkg::A_ISR && pwdata[ursf_pkg::IS_COB]) ? 1'b0 : cob_ff)
              | brk_now | brk_end;
    end
  end

  // fill-level bid with threshold and enable gating
  always_comb
  begin
    case (mr2_ff)
      2'h0: thr = ursf_pkg::THR_ONE;
      2'h1: thr = ursf_pkg::THR_HALF;
      2'h2: thr = ursf_pkg::THR_TQ;
      default: thr = ursf_pkg::THR_FULL;
    endcase
  end
  assign bid_valid = rx_act && qi.count >= thr;
  assign bid_level = 4'(qi.count - 5'h01);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_brk_hi2;
    center && state_ff == ursf_pkg::S_BRK && rxd && hi_seen_ff;
  endsequence
  sequence s_ovr_start;
    start_ok && hold_v_ff && !qi.push_ready;
  endsequence

  a_break_zero: assert property (@(posedge pclk) disable iff (!presetn)
    qi.push_valid && qi.push_data[ursf_pkg::E_BRK] |-> qi.push_data[7:0] == 8'h00)
    else $error("break entry with non-zero data");
  a_break_end: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !cmd_rst_rx && rx_act) and s_brk_hi2 |=> state_ff == ursf_pkg::S_IDLE && cob_ff)
    else $error("break end not taken");
  a_break_start: assert property (@(posedge pclk) disable iff (!presetn)
    ce && brk_now && !cmd_rst_rx |=> cob_ff && hold_ff[ursf_pkg::E_BRK] && hold_v_ff)
    else $error("break start flags missing");
  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    (ce) and s_ovr_start |=> ovr_ff)
    else $error("overrun not flagged at start bit");
  a_queue_kept: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !qi.push_ready && !pop_fire && !cmd_rst_rx |=> qi.count == $past(qi.count))
    else $error("full queue changed without a pop");
  a_status_nopop: assert property (@(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == ursf_pkg::A_SR && !push_fire |=> qi.count == $past(qi.count))
    else $error("status read changed the queue");
  a_bid_code: assert property (@(posedge pclk) disable iff (!presetn)
    bid_valid |-> qi.count != 5'h00 && {1'b0, bid_level} == qi.count - 5'h01)
    else $error("bid level wrong");
  a_bid_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_act |-> !bid_valid)
    else $error("disabled receiver bids");
  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && latch_ff[0] && !cmd_clr_err && !cmd_rst_rx) ##1 (!cmd_clr_err && !cmd_rst_rx)
    |=> latch_ff[0])
    else $error("block latch dropped");
endmodule
`default_nettype wire

// File: src/ursf_pkg.sv
// constants shared by the receive status and queue block
package ursf_pkg;
  // register byte offsets
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_MR1  = 8'h04;
  localparam logic [7:0] A_MR2  = 8'h08;
  localparam logic [7:0] A_SR   = 8'h0C;
  localparam logic [7:0] A_RXD  = 8'h10;
  localparam logic [7:0] A_ISR  = 8'h14;
  localparam logic [7:0] A_BID  = 8'h18;
  // command_reg write-one pulses
  localparam int C_RST_ERR  = 0;
  localparam int C_RST_RX   = 1;
  localparam int C_ON_PUSH  = 2;
  localparam int C_ON_READ  = 3;
  // first_mode_reg fields
  localparam int M1_BLOCK   = 0;
  localparam int M1_RX_EN   = 1;
  localparam int M1_PAR_EN  = 2;
  localparam int M1_PAR_ODD = 3;
  localparam int M1_SPECIAL = 4;
  localparam logic [4:0] MR1_RST = 5'h00;
  // second_mode_reg threshold field
  localparam int M2_THR_LO  = 2;
  localparam logic [1:0] MR2_RST = 2'h0;
  // channel_status_reg / interrupt_status_reg bits, and the valid bit of the bid register
  localparam int SR_READY = 0;
  localparam int SR_FULL  = 1;
  localparam int SR_OVR   = 4;
  localparam int SR_ERR_LO = 5;
  localparam int IS_BID   = 0;
  localparam int IS_COB   = 2;
  localparam int BID_V    = 4;
  // queue entry layout: {break, framing, parity, data}
  localparam int Q_WIDTH = 11;
  localparam int Q_DEPTH = 16;
  localparam int E_BRK = 10;
  localparam int E_FE  = 9;
  localparam int E_PE  = 8;
  // fill levels for the bid threshold
  localparam logic [4:0] THR_ONE  = 5'h01;
  localparam logic [4:0] THR_HALF = 5'h08;
  localparam logic [4:0] THR_TQ   = 5'h0C;
  localparam logic [4:0] THR_FULL = 5'h10;
  // 16x bit timing
  localparam logic [3:0] T_START_OK = 4'h7;
  localparam logic [3:0] T_BIT_LAST = 4'hF;
  localparam logic [3:0] N_DATA     = 4'h8;
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_BRK} ursf_state_t;
endpackage

// File: src/ursf_q_if.sv
// interface between the receiver logic and its queue
`timescale 1ns/1ps
`default_nettype none
interface ursf_q_if;
  logic                        push_valid;
  logic [ursf_pkg::Q_WIDTH-1:0] push_data;
  logic                        push_ready;
  logic                        pop;
  logic                        flush;
  logic [ursf_pkg::Q_WIDTH-1:0] head;
  logic                        head_valid;
  logic [4:0]                  count;
  modport owner (output push_valid, push_data, pop, flush,
                 input push_ready, head, head_valid, count);
  modport queue (input push_valid, push_data, pop, flush,
                 output push_ready, head, head_valid, count);
endinterface
`default_nettype wire

// File: src/ursf_queue.sv
// receive queue: entries of data plus status, first in first out
`timescale 1ns/1ps
`default_nettype none
module ursf_queue #(
  parameter int DEPTH = ursf_pkg::Q_DEPTH,
  parameter int WIDTH = ursf_pkg::Q_WIDTH
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // owner side
  ursf_q_if.queue   q
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH != 16 || WIDTH != 11)
    begin : g_chk
      $error("ursf_queue: depth 16 and width 11 only");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [4:0]       cnt_ff;
  logic             do_push;
  logic             do_pop;

  ////////////////////////////////////////////////////////////////////////////
  // handshake terms
  assign q.push_ready = (cnt_ff != ursf_pkg::THR_FULL);
  assign q.head_valid = (cnt_ff != 5'h00);
  assign q.head       = mem[rd_ff];
  assign q.count      = cnt_ff;
  assign do_push      = q.push_valid & q.push_ready;
  assign do_pop       = q.pop & q.head_valid;

  // storage array, written only on an accepted push
  always_ff @(posedge pclk)
  begin
    if (ce && do_push && !q.flush)
    begin
      mem[wr_ff] <= q.push_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= 5'h00;
    end
    else if (ce)
    begin
      if (q.flush)
      begin
        wr_ff  <= '0;
        rd_ff  <= '0;
        cnt_ff <= 5'h00;
      end
      else
      begin
        if (do_push)
          wr_ff <= wr_ff + 1'b1;
        if (do_pop)
          rd_ff <= rd_ff + 1'b1;
        cnt_ff <= cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/ursf_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module ursf_tx_model #(
  parameter int BIT = 16
) (
  // clock of the bench
  input  wire logic pclk,
  // serial line, idle high
  output var logic  rxd
);
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // hold the line at one level for n bit times, changing just after an edge
  task automatic level(input logic v, input int n);
    rxd <= v;
    repeat (n * BIT) @(posedge pclk);
  endtask
  // one frame: start, eight bits lsb first, optional parity, stop, idle gap
  task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
    int i;
    level(1'b0, 1);
    for (i = 0; i < 8; i++)
      level(d[i], 1);
    if (pe)
      level(pb, 1);
    level(sb, 1);
    level(1'b1, 1);
  endtask
endmodule
`default_nettype wire

// File: verif/test_uart_rx_status_fifo.sv
// self-checking bench for the receive status and queue block
`timescale 1ns/1ps
`default_nettype none
module test_uart_rx_status_fifo;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        rxd;
  logic        bid_valid;
  logic [3:0]  bid_level;
  int          failures;
  int          tests_run;
  int          cycles;
  // design with one pclk per 16x tick, so a bit lasts 16 cycles
  ursf_top #(.BAUD16_DIV(1)) dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .bid_valid(bid_valid),
    .bid_level(bid_level)
  );
  ursf_tx_model #(.BIT(16)) tx (.pclk(pclk), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one APB transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset state and an unmapped address
  task automatic t_reset();
    rc("mode1", ursf_pkg::A_MR1, 32'h0);
    rc("status", ursf_pkg::A_SR, 32'h0);
    chk("bid", 32'h0, {31'h0, bid_valid});
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
  endtask
  // one character, status reads do not pop, disabled receiver does not bid
  task automatic t_basic();
    apb(1'b1, ursf_pkg::A_MR1, 32'h2);
    tx.send(8'h5A, 1'b0, 1'b0, 1'b1);
    chk("bid", 32'h1, {31'h0, bid_valid});
    chk("level", 32'h0, {28'h0, bid_level});
    rc("status", ursf_pkg::A_SR, 32'h1);
    rc("status", ursf_pkg::A_SR, 32'h1);
    apb(1'b1, ursf_pkg::A_MR1, 32'h0);
    @(negedge pclk);
    chk("bid off", 32'h0, {31'h0, bid_valid});
    apb(1'b1, ursf_pkg::A_MR1, 32'h10);
    @(negedge pclk);
    chk("bid special", 32'h1, {31'h0, bid_valid});
    rc("bid reg", ursf_pkg::A_BID, 32'h10);
    apb(1'b1, ursf_pkg::A_MR1, 32'h2);
    rc("data", ursf_pkg::A_RXD, 32'h5A);
    rc("status", ursf_pkg::A_SR, 32'h0);
  endtask
  // parity, framing and character-mode head status
  task automatic t_errors();
    apb(1'b1, ursf_pkg::A_MR1, 32'h6);
    tx.send(8'h33, 1'b1, 1'b1, 1'b1);
    tx.send(8'h55, 1'b1, 1'b0, 1'b1);
    rc("status", ursf_pkg::A_SR, 32'h21);
    rc("data", ursf_pkg::A_RXD, 32'h33);
    rc("status", ursf_pkg::A_SR, 32'h1);
    rc("data", ursf_pkg::A_RXD, 32'h55);
    apb(1'b1, ursf_pkg::A_MR1, 32'hE);
    tx.send(8'h0F, 1'b1, 1'b1, 1'b1);
    tx.send(8'h81, 1'b1, 1'b1, 1'b0);
    rc("status", ursf_pkg::A_SR, 32'h1);
    rc("data", ursf_pkg::A_RXD, 32'h0F);
    rc("status", ursf_pkg::A_SR, 32'h41);
    rc("data", ursf_pkg::A_RXD, 32'h81);
  endtask
  // break start and end
  task automatic t_break();
    apb(1'b1, ursf_pkg::A_MR1, 32'h2);
    tx.level(1'b0, 14);
    rc("isr", ursf_pkg::A_ISR, 32'h5);
    rc("status", ursf_pkg::A_SR, 32'h81);
    apb(1'b1, ursf_pkg::A_ISR, 32'h4);
    rc("isr", ursf_pkg::A_ISR, 32'h1);
    tx.level(1'b1, 2);
    rc("isr", ursf_pkg::A_ISR, 32'h5);
    rc("data", ursf_pkg::A_RXD, 32'h0);
    rc("status", ursf_pkg::A_SR, 32'h0);
    apb(1'b1, ursf_pkg::A_ISR, 32'h4);
  endtask
  // fill to 16, hold the 17th, overrun by the 18th, then drain
  task automatic t_full();
    int k;
    apb(1'b1, ursf_pkg::A_MR2, 32'h8);
    for (k = 1; k <= 18; k++)
    begin
      tx.send(8'(8'h10 + k), 1'b0, 1'b0, 1'b1);
      @(negedge pclk);
      if (k <= 16)
        chk("bid", {31'h0, k >= 12}, {31'h0, bid_valid});
      if (k >= 12 && k <= 16)
        chk("level", 32'(k - 1), {28'h0, bid_level});
      if (k == 17)
        rc("status", ursf_pkg::A_SR, 32'h3);
    end
    rc("status", ursf_pkg::A_SR, 32'h13);
    apb(1'b1, ursf_pkg::A_MR2, 32'hC);
    @(negedge pclk);
    chk("bid", 32'h1, {31'h0, bid_valid});
    for (k = 1; k <= 16; k++)
      rc("data", ursf_pkg::A_RXD, 32'(8'h10 + k));
    rc("data", ursf_pkg::A_RXD, 32'h22);
    rc("status", ursf_pkg::A_SR, 32'h10);
    apb(1'b1, ursf_pkg::A_CMD, 32'h1);
    rc("status", ursf_pkg::A_SR, 32'h0);
  endtask
  // block mode latches, collected on read-out then on push
  task automatic t_block();
    apb(1'b1, ursf_pkg::A_MR1, 32'h7);
    tx.send(8'h33, 1'b1, 1'b1, 1'b1);
    tx.send(8'h55, 1'b1, 1'b0, 1'b1);
    rc("status", ursf_pkg::A_SR, 32'h1);
    rc("data", ursf_pkg::A_RXD, 32'h33);
    rc("data", ursf_pkg::A_RXD, 32'h55);
    rc("status", ursf_pkg::A_SR, 32'h20);
    apb(1'b1, ursf_pkg::A_CMD, 32'h1);
    rc("status", ursf_pkg::A_SR, 32'h0);
    apb(1'b1, ursf_pkg::A_CMD, 32'h4);
    tx.send(8'h33, 1'b1, 1'b1, 1'b1);
    rc("status", ursf_pkg::A_SR, 32'h21);
    apb(1'b1, ursf_pkg::A_CMD, 32'h2);
    rc("status", ursf_pkg::A_SR, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset for 8 cycles, then the scenarios
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_basic();
    t_errors();
    t_break();
    t_full();
    t_block();
    give_verdict();
  end
endmodule
`default_nettype wire
